// >>> core/vsm_pkg.sv
// Constants and types shared by the slew and mode controller
package vsm_pkg;

    // Level codes of the multi-level pins, as delivered by the pad comparators
    localparam logic [1:0] VSM_LVL_GND  = 2'h0;
    localparam logic [1:0] VSM_LVL_REF  = 2'h1;
    localparam logic [1:0] VSM_LVL_OPEN = 2'h2;
    localparam logic [1:0] VSM_LVL_VCC  = 2'h3;
    // Three-level suspend select: high reads as VCC
    localparam logic [1:0] VSM_SUS_HIGH = 2'h3;

    // Offset input range codes
    localparam logic [1:0] VSM_OFS_RANGE_A = 2'h1;
    localparam logic [1:0] VSM_OFS_RANGE_B = 2'h2;

    // Register indices on the plain register port
    localparam logic [1:0] VSM_REG_SLEW   = 2'h0;
    localparam logic [1:0] VSM_REG_OFFSET = 2'h1;
    localparam logic [1:0] VSM_REG_STATUS = 2'h2;
    localparam logic [1:0] VSM_REG_CODE   = 2'h3;

    // Reset values
    localparam logic [9:0] VSM_SLEW_DIV_RST = 10'h064;
    localparam logic [3:0] VSM_OFS_A_RST    = 4'h2;
    localparam logic [3:0] VSM_OFS_B_RST    = 4'h4;

    // Suspend code bases in LSB units (lower and upper range)
    localparam logic [6:0] VSM_SUS_LOWER_BASE = 7'h10;
    localparam logic [6:0] VSM_SUS_UPPER_BASE = 7'h20;
    localparam logic [6:0] VSM_CODE_MAX       = 7'h7F;

    // Timing
    localparam int         VSM_CLK_MHZ       = 100;
    localparam int         VSM_PG_DELAY_US   = 3000;
    localparam int         VSM_PG_DELAY_CYC  = VSM_PG_DELAY_US * VSM_CLK_MHZ;
    localparam logic [4:0] VSM_BLANK_TICKS   = 5'h18;
    localparam logic [1:0] VSM_SLOW_DIV_LAST = 2'h3;
    localparam logic [1:0] VSM_DOWN_EXTRA    = 2'h2;

    typedef enum logic [2:0] {
        VSM_OFF   = 3'b000,
        VSM_START = 3'b001,
        VSM_RUN   = 3'b010,
        VSM_SHUTDOWN_N_INPUT  = 3'b011,
        VSM_FAULT = 3'b100
    } vsm_state_e;

endpackage : vsm_pkg

// >>> core/vsm_controller.sv
// Mode decode, target selection and slew control of the regulator core
// Functional notes
// - Target mux chooses normal VID, VID plus offset, or suspend code.
// - At start target is VID when suspend select grounded, else suspend code.
// - Any VID change while running starts a controlled slew to the new code.
// - Shutdown low forces low-side drive high, high-side low, controller off.
// - Pulse-skip select at ground or reference enters skip mode, blanks upper check.
// - Suspend select at reference or high overrides all modes with suspend code.
// - Fault latch holds output at ground until shutdown is toggled.
// - On-time and suspend code pins are static four-level inputs.
// - Entering suspend drops offset and slews to the suspend code.
// - Undervoltage check blanked until 24 slew ticks after reaching suspend code.
// - Suspend select at reference picks upper range, high picks lower range.
// - Power good frozen during transitions, released 24 ticks after final code.
// - Soft-start, soft-shutdown and suspend slews step exactly one LSB.
// - Slew step period programmable from 1 to 1023 clock cycles.
// - Downward transitions take two extra slew ticks.
// - Soft-start ramps from zero at a quarter of the slew rate.
// - After power-up power good stays low 3 ms past reaching target.
// - Shutdown drops power good at once and ramps down, four ticks per step.
`timescale 1ns/10ps
`default_nettype none

module vsm_controller
    import vsm_pkg::*;
#(
    parameter int PG_DELAY_CYCLES = VSM_PG_DELAY_CYC
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    // Mode and code pins
    input  wire logic       shutdown_n_input_in,
    input  wire logic [1:0] suspend_select_in,
    input  wire logic [1:0] pulse_skip_select_in,
    input  wire logic [1:0] offset_input_in,
    input  wire logic [5:0] vid_code_inputs_in,
    input  wire logic [1:0] suspend_code_bit_low_in,
    input  wire logic [1:0] suspend_code_bit_high_in,
    input  wire logic [1:0] on_time_select_in,
    // Analog monitor results
    input  wire logic       output_above_lower_in,
    input  wire logic       output_below_upper_in,
    input  wire logic       undervoltage_detect_in,
    input  wire logic       overvoltage_detect_in,
    input  wire logic       thermal_detect_in,
    // Register port
    input  wire logic [1:0] reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [15:0]     reg_rdata_out,
    // Controller outputs
    output logic [6:0]      applied_code_out,
    output logic [6:0]      target_code_out,
    output logic            low_side_gate_drive_out,
    output logic            high_side_gate_drive_out,
    output logic            controller_enable_out,
    output logic            pulse_skip_mode_out,
    output logic            upper_check_blank_out,
    output logic            undervoltage_protect_en_out,
    output logic            power_good_output_out,
    output logic            fault_latched_out,
    output logic [1:0]      on_time_select_out
);

    typedef struct packed {
        vsm_state_e  st;
        logic [6:0]  code;
        logic [6:0]  tgt;
        logic [9:0]  tick_cnt;
        logic [1:0]  slow_cnt;
        logic [1:0]  down_wait;
        logic [4:0]  blank_cnt;
        logic        blanking;
        logic [31:0] pg_cnt;
        logic        pg_armed;
        logic        pg;
        logic        fault;
        logic        skip;
        logic        uv_en;
        logic        dl;
        logic        dh;
        logic        en;
        logic [1:0]  on_time_select;
        logic [9:0]  slew_div;
        logic [3:0]  ofs_a;
        logic [3:0]  ofs_b;
        logic [15:0] rdata;
    } vsm_core_s;

    vsm_core_s cur_reg;
    vsm_core_s cur_next;

    // Suspend code from range select and the two four-level code pins
    function automatic logic [6:0] vsm_sus_code(input logic [1:0] sel,
                                                input logic [1:0] s_hi,
                                                input logic [1:0] s_lo);
        logic [6:0] base;
        base = (sel == VSM_SUS_HIGH) ? VSM_SUS_LOWER_BASE : VSM_SUS_UPPER_BASE;
        return base + {3'h0, s_hi, s_lo};
    endfunction

    // Target mux, offset saturates at the top code
    function automatic logic [6:0] vsm_target(input logic [1:0] sel,
                                              input logic [1:0] ofs,
                                              input logic [5:0] vid,
                                              input logic [1:0] s_hi,
                                              input logic [1:0] s_lo,
                                              input logic [3:0] oa,
                                              input logic [3:0] ob);
        logic [7:0] sum;
        sum = {2'h0, vid};
        if (sel != VSM_LVL_GND) begin
            return vsm_sus_code(sel, s_hi, s_lo);
        end
        if (ofs == VSM_OFS_RANGE_A) begin
            sum = sum + {4'h0, oa};
        end else if (ofs == VSM_OFS_RANGE_B) begin
            sum = sum + {4'h0, ob};
        end
        return (sum > {1'b0, VSM_CODE_MAX}) ? VSM_CODE_MAX : sum[6:0];
    endfunction

    logic [6:0] tgt_sel;
    logic       tick;
    logic       slow_tick;
    logic       fault_evt;

    always_comb begin
        tgt_sel   = vsm_target(suspend_select_in, offset_input_in, vid_code_inputs_in,
                               suspend_code_bit_high_in, suspend_code_bit_low_in,
                               cur_reg.ofs_a, cur_reg.ofs_b);
        tick      = (cur_reg.tick_cnt >= cur_reg.slew_div - 10'h001);
        slow_tick = tick && (cur_reg.slow_cnt == VSM_SLOW_DIV_LAST);
        fault_evt = overvoltage_detect_in || thermal_detect_in
                    || (undervoltage_detect_in && cur_reg.uv_en);

        cur_next       = cur_reg;
        cur_next.tgt   = tgt_sel;
        cur_next.on_time_select   = on_time_select_in;
        cur_next.skip  = (pulse_skip_select_in == VSM_LVL_GND)
                         || (pulse_skip_select_in == VSM_LVL_REF);
        cur_next.tick_cnt = tick ? 10'h000 : cur_reg.tick_cnt + 10'h001;
        if (tick) begin
            cur_next.slow_cnt = cur_reg.slow_cnt + 2'h1;
        end

        unique case (cur_reg.st)
            VSM_OFF: begin
                cur_next.code = 7'h00;
                if (shutdown_n_input_in && !cur_reg.fault) begin
                    cur_next.st       = VSM_START;
                    cur_next.slow_cnt = 2'h0;
                    cur_next.blanking = 1'b1;
                end
            end
            VSM_START: begin
                // Quarter-rate ramp up from zero
                if (slow_tick && cur_reg.code < cur_reg.tgt) begin
                    cur_next.code = cur_reg.code + 7'h01;
                end
                if (cur_reg.code >= cur_reg.tgt) begin
                    cur_next.st        = VSM_RUN;
                    cur_next.blank_cnt = VSM_BLANK_TICKS;
                    cur_next.pg_cnt    = 32'h0;
                    cur_next.pg_armed  = 1'b0;
                end
            end
            VSM_RUN: begin
                if (cur_reg.code != cur_reg.tgt) begin
                    cur_next.blanking  = 1'b1;
                    cur_next.blank_cnt = VSM_BLANK_TICKS;
                    if (tick) begin
                        if (cur_reg.code < cur_reg.tgt) begin
                            cur_next.code = cur_reg.code + 7'h01;
                        end else if (cur_reg.down_wait < VSM_DOWN_EXTRA) begin
                            cur_next.down_wait = cur_reg.down_wait + 2'h1;
                        end else begin
                            cur_next.code = cur_reg.code - 7'h01;
                        end
                    end
                end else begin
                    cur_next.down_wait = 2'h0;
                    if (tick && cur_reg.blank_cnt != 5'h00) begin
                        cur_next.blank_cnt = cur_reg.blank_cnt - 5'h01;
                    end
                    if (cur_reg.blank_cnt == 5'h00) begin
                        cur_next.blanking = 1'b0;
                    end
                end
                if (!cur_reg.pg_armed) begin
                    // Power-up hold off, long count is a parameter
                    if (cur_reg.pg_cnt >= 32'(PG_DELAY_CYCLES - 1)) begin
                        cur_next.pg_armed = 1'b1;
                    end else begin
                        cur_next.pg_cnt = cur_reg.pg_cnt + 32'h1;
                    end
                end
            end
            VSM_SHUTDOWN_N_INPUT, VSM_FAULT: begin
                // Slow ramp avoids negative output swing
                if (slow_tick && cur_reg.code != 7'h00) begin
                    cur_next.code = cur_reg.code - 7'h01;
                end
                if (cur_reg.st == VSM_SHUTDOWN_N_INPUT && cur_reg.code == 7'h00) begin
                    cur_next.st = VSM_OFF;
                end
            end
            default: begin
                cur_next.st = VSM_OFF;
            end
        endcase

        // Fault latch: cleared only by shutdown going low
        if (!shutdown_n_input_in) begin
            cur_next.fault = 1'b0;
            if (cur_reg.st != VSM_OFF && cur_reg.st != VSM_SHUTDOWN_N_INPUT) begin
                cur_next.st       = VSM_SHUTDOWN_N_INPUT;
                cur_next.slow_cnt = 2'h0;
            end
        end else if (fault_evt && cur_reg.st != VSM_OFF) begin
            cur_next.fault = 1'b1;
            cur_next.st    = VSM_FAULT;
        end

        // Power good follows the window only when not blanked; shutdown, fault or leaving run force it low
        if (!shutdown_n_input_in || cur_next.st != VSM_RUN || cur_reg.fault) begin
            cur_next.pg = 1'b0;
        end else if (!cur_reg.blanking && cur_reg.pg_armed) begin
            cur_next.pg = output_above_lower_in
                          && (output_below_upper_in || cur_reg.skip);
        end
        cur_next.uv_en = (cur_next.st == VSM_RUN) && !cur_next.blanking;

        // Gate drive: parked with low side on when idle at ground
        cur_next.en = (cur_next.st == VSM_START) || (cur_next.st == VSM_RUN)
                      || ((cur_next.st == VSM_SHUTDOWN_N_INPUT) && shutdown_n_input_in);
        if (!shutdown_n_input_in || cur_next.st == VSM_OFF
            || (cur_next.st == VSM_FAULT && cur_next.code == 7'h00)) begin
            cur_next.en = 1'b0;
            cur_next.dl = 1'b1;
            cur_next.dh = 1'b0;
        end else begin
            cur_next.dl = 1'b0;
            cur_next.dh = 1'b0;
        end
        // Register port
        cur_next.rdata = 16'h0000;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                VSM_REG_SLEW: begin
                    if (reg_wdata_in[9:0] != 10'h000) begin
                        cur_next.slew_div = reg_wdata_in[9:0];
                    end
                end
                VSM_REG_OFFSET: begin
                    cur_next.ofs_a = reg_wdata_in[3:0];
                    cur_next.ofs_b = reg_wdata_in[7:4];
                end
                VSM_REG_STATUS, VSM_REG_CODE: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                VSM_REG_SLEW:   cur_next.rdata = {6'h00, cur_reg.slew_div};
                VSM_REG_OFFSET: cur_next.rdata = {8'h00, cur_reg.ofs_b, cur_reg.ofs_a};
                VSM_REG_STATUS: cur_next.rdata = {8'h00, cur_reg.skip, cur_reg.uv_en,
                                                  cur_reg.blanking, cur_reg.pg,
                                                  cur_reg.fault, cur_reg.st};
                VSM_REG_CODE:   cur_next.rdata = {1'b0, cur_reg.tgt, 1'b0, cur_reg.code};
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur_reg          <= '0;
            cur_reg.st       <= VSM_OFF;
            cur_reg.dl       <= 1'b1;
            cur_reg.blanking <= 1'b1;
            cur_reg.slew_div <= VSM_SLEW_DIV_RST;
            cur_reg.ofs_a    <= VSM_OFS_A_RST;
            cur_reg.ofs_b    <= VSM_OFS_B_RST;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata_out               = cur_reg.rdata;
    assign applied_code_out            = cur_reg.code;
    assign target_code_out             = cur_reg.tgt;
    assign low_side_gate_drive_out     = cur_reg.dl;
    assign high_side_gate_drive_out    = cur_reg.dh;
    assign controller_enable_out       = cur_reg.en;
    assign pulse_skip_mode_out         = cur_reg.skip;
    assign upper_check_blank_out       = cur_reg.skip;
    assign undervoltage_protect_en_out = cur_reg.uv_en;
    assign power_good_output_out       = cur_reg.pg;
    assign fault_latched_out           = cur_reg.fault;
    assign on_time_select_out          = cur_reg.on_time_select;

    property p_shutdown_n_input_pg;
        @(posedge clk_in) disable iff (!resetn_in)
        !shutdown_n_input_in |=> !power_good_output_out && low_side_gate_drive_out;
    endproperty
    a_shutdown_n_input_pg: assert property (p_shutdown_n_input_pg) else $error("power good or drive wrong in shutdown");

    property p_off_gates;
        @(posedge clk_in) disable iff (!resetn_in)
        (cur_reg.st == VSM_OFF) |-> low_side_gate_drive_out && !high_side_gate_drive_out
                                    && !controller_enable_out;
    endproperty
    a_off_gates: assert property (p_off_gates) else $error("gate drive not parked");

    property p_fault_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        fault_latched_out && shutdown_n_input_in |=> fault_latched_out;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault latch lost");

    property p_one_lsb;
        @(posedge clk_in) disable iff (!resetn_in)
        $changed(applied_code_out) |->
            (applied_code_out == $past(applied_code_out) + 7'h01)
            || (applied_code_out == $past(applied_code_out) - 7'h01);
    endproperty
    a_one_lsb: assert property (p_one_lsb) else $error("code moved more than one step");

    property p_pg_frozen;
        @(posedge clk_in) disable iff (!resetn_in)
        cur_reg.blanking && shutdown_n_input_in && cur_reg.st == VSM_RUN
            && !fault_latched_out ##1 cur_reg.st == VSM_RUN |-> $stable(power_good_output_out);
    endproperty
    a_pg_frozen: assert property (p_pg_frozen) else $error("power good moved while blanked");

    property p_uv_blank;
        @(posedge clk_in) disable iff (!resetn_in)
        (cur_reg.code != cur_reg.tgt) |=> !undervoltage_protect_en_out;
    endproperty
    a_uv_blank: assert property (p_uv_blank) else $error("undervoltage check active in slew");

    property p_skip_mode;
        @(posedge clk_in) disable iff (!resetn_in)
        (pulse_skip_select_in == VSM_LVL_GND) |=> pulse_skip_mode_out && upper_check_blank_out;
    endproperty
    a_skip_mode: assert property (p_skip_mode) else $error("skip mode not entered");

    property p_sus_target;
        @(posedge clk_in) disable iff (!resetn_in)
        (suspend_select_in == VSM_LVL_REF) |=>
            target_code_out == VSM_SUS_UPPER_BASE
                + {3'h0, $past(suspend_code_bit_high_in), $past(suspend_code_bit_low_in)};
    endproperty
    a_sus_target: assert property (p_sus_target) else $error("suspend target wrong");

    property p_hold_equal;
        @(posedge clk_in) disable iff (!resetn_in)
        cur_reg.st == VSM_RUN && cur_next.st == VSM_RUN && cur_reg.code == cur_reg.tgt
            |=> $stable(applied_code_out);
    endproperty
    a_hold_equal: assert property (p_hold_equal) else $error("code moved at target");

endmodule // vsm_controller

`default_nettype wire

// >>> verification/vsm_host_model.sv
// Host model driving the mode, code and level pins of the controller
`timescale 1ns/10ps
`default_nettype none

module vsm_host_model
    import vsm_pkg::*;
(
    // Clock
    input  wire logic       clk_in,
    // Pins toward the controller
    output logic            shutdown_n_out,
    output logic [1:0]      sus_sel_out,
    output logic [1:0]      skip_out,
    output logic [1:0]      ofs_out,
    output logic [5:0]      vid_out,
    output logic [1:0]      s_lo_out,
    output logic [1:0]      s_hi_out,
    output logic [1:0]      ton_out
);
    initial begin
        shutdown_n_out = 1'b0;
        sus_sel_out    = VSM_LVL_GND;
        skip_out       = VSM_LVL_VCC;
        ofs_out        = 2'h0;
        vid_out        = 6'h0A;
        s_lo_out       = VSM_LVL_GND;
        s_hi_out       = VSM_LVL_GND;
        ton_out        = VSM_LVL_REF;
    end

    // Whole word in one edge, no skew between bits
    task automatic set_vid(input logic [5:0] v);
        @(posedge clk_in);
        vid_out <= v;
    endtask

    task automatic set_mode(input logic sd, input logic [1:0] suspend_select, skp, ofs);
        @(posedge clk_in);
        shutdown_n_out <= sd;
        sus_sel_out    <= suspend_select;
        skip_out       <= skp;
        ofs_out        <= ofs;
    endtask

    // Four-level pins only change while the output is settled
    task automatic set_levels(input logic [1:0] hi, lo, on_time_select);
        @(posedge clk_in);
        s_hi_out <= hi;
        s_lo_out <= lo;
        ton_out  <= on_time_select;
    endtask
endmodule // vsm_host_model

`default_nettype wire

// >>> verification/test_vsm_controller.sv
// Self-checking bench of the slew and mode controller
`timescale 1ns/10ps
`default_nettype none

module test_vsm_controller
    import vsm_pkg::*;
;
    logic clk_in = 1'b0, resetn_in = 1'b0;
    logic output_above_lower_in = 1'b1, output_below_upper_in = 1'b1;
    logic undervoltage_detect_in = 1'b0, overvoltage_detect_in = 1'b0, thermal_detect_in = 1'b0;
    logic [1:0] reg_addr_in = 2'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    wire logic shutdown_n_input_in;
    wire logic [1:0] suspend_select_in, pulse_skip_select_in, offset_input_in;
    wire logic [5:0] vid_code_inputs_in;
    wire logic [1:0] suspend_code_bit_low_in, suspend_code_bit_high_in, on_time_select_in;
    wire logic [15:0] reg_rdata_out;
    wire logic [6:0] applied_code_out, target_code_out;
    wire logic low_side_gate_drive_out, high_side_gate_drive_out, controller_enable_out;
    wire logic pulse_skip_mode_out, upper_check_blank_out, undervoltage_protect_en_out;
    wire logic power_good_output_out, fault_latched_out;
    wire logic [1:0] on_time_select_out;
    int bad_count = 0, n_checks = 0, n, n_up;
    logic [15:0] rd;

    always #5 clk_in = ~clk_in;

    vsm_host_model vsm_host_model_inst (.clk_in, .shutdown_n_out(shutdown_n_input_in),
        .sus_sel_out(suspend_select_in), .skip_out(pulse_skip_select_in),
        .ofs_out(offset_input_in), .vid_out(vid_code_inputs_in),
        .s_lo_out(suspend_code_bit_low_in), .s_hi_out(suspend_code_bit_high_in),
        .ton_out(on_time_select_in));

    vsm_controller #(.PG_DELAY_CYCLES(50)) vsm_controller_inst (.clk_in, .resetn_in,
        .shutdown_n_input_in, .suspend_select_in, .pulse_skip_select_in, .offset_input_in,
        .vid_code_inputs_in, .suspend_code_bit_low_in, .suspend_code_bit_high_in,
        .on_time_select_in, .output_above_lower_in, .output_below_upper_in,
        .undervoltage_detect_in, .overvoltage_detect_in, .thermal_detect_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .applied_code_out,
        .target_code_out, .low_side_gate_drive_out, .high_side_gate_drive_out,
        .controller_enable_out, .pulse_skip_mode_out, .upper_check_blank_out,
        .undervoltage_protect_en_out, .power_good_output_out, .fault_latched_out,
        .on_time_select_out);

    task automatic chk(input string nm, input logic [15:0] exp, got);
        n_checks++;
        if (exp !== got) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask

    // Bounded wait for the applied code to meet a value
    task automatic settle(input logic [6:0] v, input int lim, output int k);
        k = 0;
        while (applied_code_out !== v && k < lim) begin
            cyc(1);
            k++;
        end
        chk("settle", {9'h0, v}, {9'h0, applied_code_out});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #300us;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        cyc(10);
        resetn_in <= 1'b1;
        chk("ls_rst", 1, low_side_gate_drive_out);
        reg_read(VSM_REG_SLEW, rd);
        chk("slew_rst", {6'h0, VSM_SLEW_DIV_RST}, rd);
        reg_write(VSM_REG_SLEW, 16'h0000);
        reg_read(VSM_REG_SLEW, rd);
        chk("slew_zero", {6'h0, VSM_SLEW_DIV_RST}, rd);
        reg_write(VSM_REG_SLEW, 16'h0002);
        vsm_host_model_inst.set_mode(1'b1, VSM_LVL_GND, VSM_LVL_VCC, 2'h0);
        cyc(2);
        settle(7'h0A, 300, n);
        chk("tgt_start", 16'h0A, {9'h0, target_code_out});
        chk("ss_span", 1, n >= 72 && n <= 84);
        chk("pg_early", 0, power_good_output_out);
        reg_read(VSM_REG_CODE, rd);
        chk("code_reg", 16'h0A0A, rd);
        cyc(120);
        chk("pg_on", 1, power_good_output_out);
        vsm_host_model_inst.set_vid(6'h0C);
        cyc(2);
        // Window drops only once blanking holds power good
        output_above_lower_in <= 1'b0;
        settle(7'h0C, 60, n_up);
        cyc(40);
        chk("pg_frozen", 1, power_good_output_out);
        cyc(20);
        chk("pg_release", 0, power_good_output_out);
        output_above_lower_in <= 1'b1;
        vsm_host_model_inst.set_vid(6'h0A);
        cyc(2);
        settle(7'h0A, 60, n);
        chk("down_extra", 1, n > n_up + 1);
        cyc(60);
        vsm_host_model_inst.set_vid(6'h10);
        cyc(4);
        vsm_host_model_inst.set_vid(6'h12);
        cyc(2);
        settle(7'h12, 30, n);
        vsm_host_model_inst.set_mode(1'b1, VSM_LVL_GND, VSM_LVL_VCC, VSM_OFS_RANGE_A);
        cyc(3);
        chk("ofs_a", 16'h14, {9'h0, target_code_out});
        vsm_host_model_inst.set_mode(1'b1, VSM_LVL_GND, VSM_LVL_VCC, VSM_OFS_RANGE_B);
        cyc(3);
        chk("ofs_b", 16'h16, {9'h0, target_code_out});
        cyc(80);
        vsm_host_model_inst.set_levels(VSM_LVL_REF, VSM_LVL_OPEN, VSM_LVL_OPEN);
        vsm_host_model_inst.set_mode(1'b1, VSM_LVL_REF, VSM_LVL_VCC, VSM_OFS_RANGE_B);
        cyc(3);
        chk("sus_ref", 16'h26, {9'h0, target_code_out});
        chk("ton", {14'h0, VSM_LVL_OPEN}, {14'h0, on_time_select_out});
        chk("uv_blank", 0, undervoltage_protect_en_out);
        undervoltage_detect_in <= 1'b1;
        cyc(2);
        chk("uv_ignored", 0, fault_latched_out);
        undervoltage_detect_in <= 1'b0;
        settle(7'h26, 100, n);
        cyc(40);
        chk("uv_hold", 0, undervoltage_protect_en_out);
        cyc(20);
        chk("uv_back", 1, undervoltage_protect_en_out);
        vsm_host_model_inst.set_mode(1'b1, VSM_SUS_HIGH, VSM_LVL_VCC, 2'h0);
        cyc(3);
        chk("sus_high", 16'h16, {9'h0, target_code_out});
        for (int l = 0; l < 4; l++) begin
            vsm_host_model_inst.set_mode(1'b1, VSM_SUS_HIGH, 2'(l), 2'h0);
            cyc(3);
            chk("skip", l < 2, pulse_skip_mode_out);
            chk("up_blank", l < 2, upper_check_blank_out);
        end
        settle(7'h16, 100, n);
        cyc(80);
        output_below_upper_in <= 1'b0;
        cyc(2);
        chk("pg_upper", 0, power_good_output_out);
        vsm_host_model_inst.set_mode(1'b1, VSM_SUS_HIGH, VSM_LVL_GND, 2'h0);
        cyc(3);
        chk("pg_skip", 1, power_good_output_out);
        output_below_upper_in <= 1'b1;
        overvoltage_detect_in <= 1'b1;
        cyc(2);
        overvoltage_detect_in <= 1'b0;
        chk("fault", 1, fault_latched_out);
        settle(7'h00, 400, n);
        cyc(3);
        chk("fault_park", 1, low_side_gate_drive_out);
        chk("fault_hold", 1, fault_latched_out);
        vsm_host_model_inst.set_mode(1'b0, VSM_LVL_GND, VSM_LVL_VCC, 2'h0);
        cyc(3);
        chk("fault_clr", 0, fault_latched_out);
        vsm_host_model_inst.set_mode(1'b1, VSM_LVL_GND, VSM_LVL_VCC, 2'h0);
        cyc(2);
        settle(7'h0A, 300, n);
        vsm_host_model_inst.set_mode(1'b0, VSM_LVL_GND, VSM_LVL_VCC, 2'h0);
        cyc(2);
        chk("sd_pg", 0, power_good_output_out);
        chk("sd_dl", 1, low_side_gate_drive_out);
        chk("sd_dh", 0, high_side_gate_drive_out);
        chk("sd_en", 0, controller_enable_out);
        settle(7'h00, 300, n);
        chk("sd_span", 1, n >= 70 && n <= 84);
        tally_and_finish();
    end
endmodule // test_vsm_controller

`default_nettype wire
